// ---- include/bimad_pkg.sv ----
// bimad_pkg: offsets, reset values, command codes and carrier structs
// of the I/O and memory-mapped I/O forwarding decoder.
// assumes configuration accesses arrive as dword-aligned byte offsets.
package bimad_pkg;

   // ------------------------------------------------------------------
   // configuration offsets (byte offsets)
   // ------------------------------------------------------------------
   localparam logic [7:0] OFF_IO_WINDOW_BASE_LOW   = 8'h1C;
   localparam logic [7:0] OFF_IO_WINDOW_LIMIT_LOW  = 8'h1D;
   localparam logic [7:0] OFF_MMIO_WINDOW_BASE     = 8'h20;
   localparam logic [7:0] OFF_MMIO_WINDOW_LIMIT    = 8'h22;
   localparam logic [7:0] OFF_IO_WINDOW_BASE_HIGH  = 8'h30;
   localparam logic [7:0] OFF_IO_WINDOW_LIMIT_HIGH = 8'h32;

   // ------------------------------------------------------------------
   // fixed fields and reset values
   // ------------------------------------------------------------------
   localparam logic [3:0]  IO_ADDR_CAP_32      = 4'h1;
   localparam logic [3:0]  MMIO_LOW_NIBBLE     = 4'h0;
   localparam logic [11:0] IO_BASE_LOW_FILL    = 12'h000;
   localparam logic [11:0] IO_LIMIT_LOW_FILL   = 12'hFFF;
   localparam logic [19:0] MMIO_BASE_LOW_FILL  = 20'h00000;
   localparam logic [19:0] MMIO_LIMIT_LOW_FILL = 20'hFFFFF;
   localparam logic [3:0]  RST_IO_NIBBLE       = 4'h0;
   localparam logic [15:0] RST_IO_HIGH         = 16'h0000;
   localparam logic [11:0] RST_MMIO_FIELD      = 12'h000;
   localparam logic [15:0] ISA_SPACE_HIGH      = 16'h0000;
   localparam logic [1:0]  ISA_LOW_QUARTER     = 2'h0;

   // ------------------------------------------------------------------
   // bus commands that read memory
   // ------------------------------------------------------------------
   localparam logic [3:0] CMD_MEM_READ       = 4'h6;
   localparam logic [3:0] CMD_MEM_READ_MULTI = 4'hC;
   localparam logic [3:0] CMD_MEM_READ_LINE  = 4'hE;

   // ------------------------------------------------------------------
   // carriers
   // ------------------------------------------------------------------
   typedef struct packed {
      logic        valid;
      logic        secondary;   // 0: started on primary, 1: on secondary
      logic        is_io;       // 0: memory transaction
      logic [3:0]  command;
      logic [31:0] addr;
   } bimad_req_s;

   typedef struct packed {
      logic        valid;
      logic        secondary;
      logic        is_io;
      logic        fwd_down;
      logic        fwd_up;
      logic        single_xfer;
      logic [31:0] addr;
   } bimad_dec_s;

   typedef struct packed {
      logic        wr;
      logic        rd;
      logic [7:0]  addr;
      logic [3:0]  be;
      logic [31:0] wdata;
   } bimad_cfg_s;

endpackage : bimad_pkg

// ---- hdl/bimad_decoder.sv ----
// bimad_decoder: forwarding decision for I/O and non-prefetchable memory
// transactions of a two-port bridge, plus the window registers.
// assumes requests and configuration accesses come from logic on i_clk;
// prefetchable and VGA claims are decided elsewhere and arrive as inputs.
//
// Functional notes
// - forward in-window primary transactions down, out-of-window secondary ones up.
// - address passes through unchanged in both directions.
// - primary I/O ignored unless I/O-space enable is set.
// - secondary I/O and memory ignored unless bus-master enable is set.
// - I/O inside base..limit goes down; secondary I/O outside goes up.
// - base above limit: no I/O down, all eligible secondary I/O up.
// - byte 1Ch holds base bits 15:12, low nibble reads 1h.
// - 16-bit register at 30h holds base bits 31:16; base resets zero.
// - byte 1Dh holds limit bits 15:12, low nibble 1h, low bits FFFh.
// - 16-bit register at 32h holds limit bits 31:16; resets 0000 0FFFh.
// - ISA filter only for in-window addresses below 64KB.
// - ISA mode blocks downstream of top 768 bytes per 1KB block.
// - ISA mode sends top 768 bytes below 64KB upstream from secondary.
// - addresses at or above 64KB use plain base/limit decode.
// - memory goes down only with memory-space enable set.
// - primary memory in MMIO window goes down; secondary in window ignored.
// - memory outside window: primary ignored, secondary up unless otherwise claimed.
// - MMIO base/limit bits 15:4 are address 31:20; low nibble reads zero.
// - after reset MMIO window spans 0000 0000h to 000F FFFFh.
// - MMIO base above limit disables the window.
// - only read-line and read-multiple prefetch; plain read is single transfer.
`timescale 1ns/1ps

module bimad_decoder
   import bimad_pkg::*;
(
   input  wire logic        i_clk,
   input  wire logic        i_reset_n,
   input  wire bimad_cfg_s  i_cfg,
   input  wire logic        i_io_space_en,
   input  wire logic        i_mem_space_en,
   input  wire logic        i_bus_master_en,
   input  wire logic        i_isa_en,
   input  wire logic        i_pref_claim,
   input  wire logic        i_vga_claim,
   input  wire bimad_req_s  i_req,
   output logic             o_cfg_rvalid,
   output logic [31:0]      o_cfg_rdata,
   output bimad_dec_s       o_dec
);

   // ------------------------------------------------------------------
   // state
   // ------------------------------------------------------------------
   typedef struct packed {
      logic [3:0]  io_base_nib;
      logic [3:0]  io_lim_nib;
      logic [15:0] io_base_hi;
      logic [15:0] io_lim_hi;
      logic [11:0] mmio_base;
      logic [11:0] mmio_lim;
      logic        rvalid;
      logic [31:0] rdata;
      bimad_dec_s  dec;
   } bimad_state_s;

   bimad_state_s q;
   bimad_state_s next_q;

   logic [31:0] io_base;
   logic [31:0] io_limit;
   logic [31:0] mmio_base;
   logic [31:0] mmio_limit;
   logic        in_io;
   logic        in_mmio;
   logic        below_64k;
   logic        isa_top;

   // ------------------------------------------------------------------
   // helpers
   // ------------------------------------------------------------------
   // unsigned compare; base above limit never matches
   function automatic logic in_window(input logic [31:0] a,
                                      input logic [31:0] base,
                                      input logic [31:0] limit);
      in_window = (a >= base) && (a <= limit);
   endfunction : in_window

   function automatic logic dword_hit(input logic [7:0] a, input logic [7:0] off);
      dword_hit = (a[7:2] == off[7:2]);
   endfunction : dword_hit

   // ------------------------------------------------------------------
   // window decode
   // ------------------------------------------------------------------
   always_comb
   begin
      io_base    = {q.io_base_hi, q.io_base_nib, IO_BASE_LOW_FILL};
      io_limit   = {q.io_lim_hi, q.io_lim_nib, IO_LIMIT_LOW_FILL};
      mmio_base  = {q.mmio_base, MMIO_BASE_LOW_FILL};
      mmio_limit = {q.mmio_lim, MMIO_LIMIT_LOW_FILL};
      in_io      = in_window(i_req.addr, io_base, io_limit);
      in_mmio    = in_window(i_req.addr, mmio_base, mmio_limit);
      below_64k  = (i_req.addr[31:16] == ISA_SPACE_HIGH);
      isa_top    = i_isa_en && below_64k && (i_req.addr[9:8] != ISA_LOW_QUARTER);
   end

   // ------------------------------------------------------------------
   // next state
   // ------------------------------------------------------------------
   always_comb
   begin
      next_q = q;

      // configuration writes
      if (i_cfg.wr)
      begin
         if (dword_hit(i_cfg.addr, OFF_IO_WINDOW_BASE_LOW))
         begin
            if (i_cfg.be[OFF_IO_WINDOW_BASE_LOW[1:0]])
               next_q.io_base_nib = i_cfg.wdata[7:4];
            if (i_cfg.be[OFF_IO_WINDOW_LIMIT_LOW[1:0]])
               next_q.io_lim_nib = i_cfg.wdata[15:12];
         end
         if (dword_hit(i_cfg.addr, OFF_MMIO_WINDOW_BASE))
         begin
            if (i_cfg.be[0])
               next_q.mmio_base[3:0] = i_cfg.wdata[7:4];
            if (i_cfg.be[1])
               next_q.mmio_base[11:4] = i_cfg.wdata[15:8];
            if (i_cfg.be[2])
               next_q.mmio_lim[3:0] = i_cfg.wdata[23:20];
            if (i_cfg.be[3])
               next_q.mmio_lim[11:4] = i_cfg.wdata[31:24];
         end
         if (dword_hit(i_cfg.addr, OFF_IO_WINDOW_BASE_HIGH))
         begin
            if (i_cfg.be[0])
               next_q.io_base_hi[7:0] = i_cfg.wdata[7:0];
            if (i_cfg.be[1])
               next_q.io_base_hi[15:8] = i_cfg.wdata[15:8];
            if (i_cfg.be[2])
               next_q.io_lim_hi[7:0] = i_cfg.wdata[23:16];
            if (i_cfg.be[3])
               next_q.io_lim_hi[15:8] = i_cfg.wdata[31:24];
         end
      end

      // configuration reads, answered one cycle later
      next_q.rvalid = i_cfg.rd;
      next_q.rdata  = 32'h00000000;
      if (i_cfg.rd)
      begin
         if (dword_hit(i_cfg.addr, OFF_IO_WINDOW_BASE_LOW))
            next_q.rdata = {16'h0000, q.io_lim_nib, IO_ADDR_CAP_32,
                            q.io_base_nib, IO_ADDR_CAP_32};
         else if (dword_hit(i_cfg.addr, OFF_MMIO_WINDOW_BASE))
            next_q.rdata = {q.mmio_lim, MMIO_LOW_NIBBLE,
                            q.mmio_base, MMIO_LOW_NIBBLE};
         else if (dword_hit(i_cfg.addr, OFF_IO_WINDOW_BASE_HIGH))
            next_q.rdata = {q.io_lim_hi, q.io_base_hi};
      end

      // forwarding decision
      next_q.dec.valid       = i_req.valid;
      next_q.dec.secondary   = i_req.secondary;
      next_q.dec.is_io       = i_req.is_io;
      next_q.dec.addr        = i_req.addr;
      next_q.dec.fwd_down    = 1'b0;
      next_q.dec.fwd_up      = 1'b0;
      next_q.dec.single_xfer = 1'b0;
      if (i_req.valid)
      begin
         if (!i_req.secondary)
         begin
            if (i_req.is_io)
               next_q.dec.fwd_down = i_io_space_en && in_io && !isa_top;
            else
               next_q.dec.fwd_down = i_mem_space_en && in_mmio;
            next_q.dec.single_xfer = !i_req.is_io && in_mmio &&
                                     (i_req.command == CMD_MEM_READ);
         end
         else if (i_bus_master_en)
         begin
            if (i_req.is_io)
               next_q.dec.fwd_up = !in_io || isa_top;
            else
               next_q.dec.fwd_up = !in_mmio && !i_pref_claim
                                   && !i_vga_claim;
         end
      end
   end

   // ------------------------------------------------------------------
   // registers
   // ------------------------------------------------------------------
   always_ff @(posedge i_clk or negedge i_reset_n)
   begin
      if (!i_reset_n)
      begin
         q             <= '0;
         q.io_base_nib <= RST_IO_NIBBLE;
         q.io_lim_nib  <= RST_IO_NIBBLE;
         q.io_base_hi  <= RST_IO_HIGH;
         q.io_lim_hi   <= RST_IO_HIGH;
         q.mmio_base   <= RST_MMIO_FIELD;
         q.mmio_lim    <= RST_MMIO_FIELD;
      end
      else
         q <= next_q;
   end

   assign o_cfg_rvalid = q.rvalid;
   assign o_cfg_rdata  = q.rdata;
   assign o_dec        = q.dec;

   // ------------------------------------------------------------------
   // checks
   // ------------------------------------------------------------------
   default clocking cb @(posedge i_clk);
   endclocking
   default disable iff (!i_reset_n);

   sequence s_pri_io;
      i_req.valid && !i_req.secondary && i_req.is_io;
   endsequence

   sequence s_pri_mem;
      i_req.valid && !i_req.secondary && !i_req.is_io;
   endsequence

   sequence s_sec_req;
      i_req.valid && i_req.secondary;
   endsequence

   sequence s_sec_io;
      i_req.valid && i_req.secondary && i_req.is_io && i_bus_master_en;
   endsequence

   sequence s_sec_mem;
      i_req.valid && i_req.secondary && !i_req.is_io && i_bus_master_en;
   endsequence

   property p_io_needs_enable;
      s_pri_io ##0 !i_io_space_en |=> o_dec.valid && !o_dec.fwd_down;
   endproperty
   a_io_needs_enable: assert property (p_io_needs_enable)
      else $error("primary I/O forwarded with I/O enable clear");

   property p_sec_needs_master;
      s_sec_req ##0 !i_bus_master_en |=> !o_dec.fwd_up && !o_dec.fwd_down;
   endproperty
   a_sec_needs_master: assert property (p_sec_needs_master)
      else $error("secondary transaction forwarded with master enable clear");

   property p_direction;
      o_dec.valid |-> !(o_dec.secondary ? o_dec.fwd_down : o_dec.fwd_up);
   endproperty
   a_direction: assert property (p_direction)
      else $error("transaction forwarded in the wrong direction");

   property p_addr_passes;
      i_req.valid |=> o_dec.addr == $past(i_req.addr);
   endproperty
   a_addr_passes: assert property (p_addr_passes)
      else $error("address altered by decode");

   property p_mmio_down;
      s_pri_mem ##0 i_mem_space_en && i_req.addr >= mmio_base
         && i_req.addr <= mmio_limit |=> o_dec.fwd_down;
   endproperty
   a_mmio_down: assert property (p_mmio_down)
      else $error("in-window memory not forwarded downstream");

   property p_mem_needs_enable;
      s_pri_mem ##0 !i_mem_space_en |=> !o_dec.fwd_down;
   endproperty
   a_mem_needs_enable: assert property (p_mem_needs_enable)
      else $error("memory forwarded with memory enable clear");

   property p_isa_block;
      s_pri_io ##0 i_isa_en && i_req.addr[31:16] == 16'h0000
         && i_req.addr[9:8] != 2'h0 |=> !o_dec.fwd_down;
   endproperty
   a_isa_block: assert property (p_isa_block)
      else $error("ISA top 768 bytes forwarded downstream");

   property p_high_io_plain;
      s_sec_req ##0 i_req.is_io && i_bus_master_en && i_req.addr[31:16] != 16'h0000
         && i_req.addr >= io_base && i_req.addr <= io_limit |=> !o_dec.fwd_up;
   endproperty
   a_high_io_plain: assert property (p_high_io_plain)
      else $error("in-window I/O above 64KB sent upstream");

   property p_io_low_reads_one;
      i_cfg.rd && i_cfg.addr[7:2] == 6'h07 |=> o_cfg_rvalid
         && o_cfg_rdata[3:0] == 4'h1 && o_cfg_rdata[11:8] == 4'h1;
   endproperty
   a_io_low_reads_one: assert property (p_io_low_reads_one)
      else $error("I/O window low nibble does not read 1h");

   property p_mmio_low_zero;
      i_cfg.rd && i_cfg.addr[7:2] == 6'h08 |=> o_cfg_rdata[3:0] == 4'h0
         && o_cfg_rdata[19:16] == 4'h0;
   endproperty
   a_mmio_low_zero: assert property (p_mmio_low_zero)
      else $error("MMIO low nibble not zero");

   property p_single_read;
      s_pri_mem ##0 i_req.command == CMD_MEM_READ
         && i_req.addr >= mmio_base && i_req.addr <= mmio_limit |=> o_dec.single_xfer;
   endproperty
   a_single_read: assert property (p_single_read)
      else $error("plain memory read in MMIO window not single transfer");

   property p_io_down;
      s_pri_io ##0 i_io_space_en && i_req.addr >= io_base && i_req.addr <= io_limit
         && !(i_isa_en && i_req.addr[31:16] == 16'h0000 && i_req.addr[9:8] != 2'h0)
         |=> o_dec.fwd_down;
   endproperty
   a_io_down: assert property (p_io_down)
      else $error("in-window primary I/O not forwarded downstream");

   property p_io_off;
      s_pri_io ##0 io_base > io_limit |=> !o_dec.fwd_down;
   endproperty
   a_io_off: assert property (p_io_off)
      else $error("primary I/O forwarded with I/O window off");

   property p_sec_io_out;
      s_sec_io ##0 (i_req.addr < io_base || i_req.addr > io_limit) |=> o_dec.fwd_up;
   endproperty
   a_sec_io_out: assert property (p_sec_io_out)
      else $error("out-of-window secondary I/O not sent upstream");

   property p_isa_up;
      s_sec_io ##0 i_isa_en && i_req.addr[31:16] == 16'h0000
         && i_req.addr[9:8] != 2'h0 |=> o_dec.fwd_up;
   endproperty
   a_isa_up: assert property (p_isa_up)
      else $error("ISA top 768 bytes not sent upstream");

   property p_high_io_down;
      s_pri_io ##0 i_io_space_en && i_req.addr[31:16] != 16'h0000
         && i_req.addr >= io_base && i_req.addr <= io_limit |=> o_dec.fwd_down;
   endproperty
   a_high_io_down: assert property (p_high_io_down)
      else $error("in-window I/O above 64KB not forwarded downstream");

   property p_sec_mem_in;
      s_sec_req ##0 !i_req.is_io && i_req.addr >= mmio_base
         && i_req.addr <= mmio_limit |=> !o_dec.fwd_up;
   endproperty
   a_sec_mem_in: assert property (p_sec_mem_in)
      else $error("secondary memory inside MMIO window sent upstream");

   property p_sec_mem_claimed;
      s_sec_req ##0 !i_req.is_io && (i_pref_claim || i_vga_claim) |=> !o_dec.fwd_up;
   endproperty
   a_sec_mem_claimed: assert property (p_sec_mem_claimed)
      else $error("claimed secondary memory sent upstream");

   property p_sec_mem_up;
      s_sec_mem ##0 !i_pref_claim && !i_vga_claim
         && (i_req.addr < mmio_base || i_req.addr > mmio_limit) |=> o_dec.fwd_up;
   endproperty
   a_sec_mem_up: assert property (p_sec_mem_up)
      else $error("unclaimed secondary memory not sent upstream");

   property p_mem_outside;
      s_pri_mem ##0 (i_req.addr < mmio_base || i_req.addr > mmio_limit) |=> !o_dec.fwd_down;
   endproperty
   a_mem_outside: assert property (p_mem_outside)
      else $error("primary memory outside MMIO window forwarded");

   property p_mmio_off;
      s_pri_mem ##0 mmio_base > mmio_limit |=> !o_dec.fwd_down;
   endproperty
   a_mmio_off: assert property (p_mmio_off)
      else $error("primary memory forwarded with MMIO window off");

   property p_io_high_write;
      i_cfg.wr && i_cfg.addr[7:2] == 6'h0C && i_cfg.be == 4'hF
         |=> {io_limit[31:16], io_base[31:16]} == $past(i_cfg.wdata);
   endproperty
   a_io_high_write: assert property (p_io_high_write)
      else $error("I/O window upper halves not written");

endmodule : bimad_decoder

// ---- verification/bimad_initiator.sv ----
// bimad_initiator: far-side initiator stage that launches one decode
// request a cycle, together with the enable and claim levels.
// assumes the bench hands it requests just after rising edges of i_clk.
`timescale 1ns/1ps

module bimad_initiator
   import bimad_pkg::*;
(
   input  wire logic       i_clk,
   input  wire logic       i_reset_n,
   input  wire bimad_req_s i_issue,
   input  wire logic [5:0] i_ctl,
   output bimad_req_s      o_req,
   output logic [5:0]      o_ctl
);
   always_ff @(posedge i_clk or negedge i_reset_n)
   begin
      if (!i_reset_n)
      begin
         o_req <= '0;
         o_ctl <= '0;
      end
      else
      begin
         o_ctl <= i_ctl;
         // released address lines keep toggling
         o_req <= i_issue.valid ? i_issue
                  : bimad_req_s'({i_issue[$bits(bimad_req_s)-1:32], ~o_req.addr});
      end
   end
endmodule : bimad_initiator

// ---- verification/bimad_decoder_tb_top.sv ----
// bimad_decoder_tb_top: self-checking bench of the forwarding decoder.
// assumes one clock at 25 MHz and the initiator stage on the request side.
`timescale 1ns/1ps

module bimad_decoder_tb_top;
   import bimad_pkg::*;
   logic        i_clk;
   logic        i_reset_n;
   bimad_cfg_s  cfg;
   bimad_req_s  issue;
   bimad_req_s  req;
   logic [5:0]  ctl;
   logic [5:0]  ctl_q;
   logic        rvalid;
   logic [31:0] rdata;
   bimad_dec_s  dec;
   bimad_dec_s  e_dec;
   logic [31:0] e_rd;
   logic [31:0] iob;
   logic [31:0] iol;
   logic [31:0] mmb;
   logic [31:0] mml;
   bimad_dec_s  dq[$];
   logic [31:0] rq[$];
   int          failures;
   int          tests_run;
   int          cycles;

   always #20 i_clk = ~i_clk;

   bimad_initiator u_init (.i_clk(i_clk), .i_reset_n(i_reset_n), .i_issue(issue),
      .i_ctl(ctl), .o_req(req), .o_ctl(ctl_q));

   bimad_decoder DUT (.i_clk(i_clk), .i_reset_n(i_reset_n), .i_cfg(cfg),
      .i_io_space_en(ctl_q[0]), .i_mem_space_en(ctl_q[1]), .i_bus_master_en(ctl_q[2]),
      .i_isa_en(ctl_q[3]), .i_pref_claim(ctl_q[4]), .i_vga_claim(ctl_q[5]),
      .i_req(req), .o_cfg_rvalid(rvalid), .o_cfg_rdata(rdata), .o_dec(dec));

   // ------------------------------------------------------------------
   // expected decode
   // ------------------------------------------------------------------
   function automatic bimad_dec_s expect_dec(input bimad_req_s r, input logic [5:0] c);
      bimad_dec_s e;
      logic       in_io;
      logic       in_mm;
      logic       isa_top;
      in_io = (r.addr >= iob) && (r.addr <= iol);
      in_mm = (r.addr >= mmb) && (r.addr <= mml);
      isa_top = c[3] && (r.addr[31:16] == 16'h0000) && (r.addr[9:8] != 2'h0);
      e = '0;
      e.valid = 1'b1;
      e.secondary = r.secondary;
      e.is_io = r.is_io;
      e.addr = r.addr;
      if (!r.secondary && r.is_io)
         e.fwd_down = c[0] && in_io && !isa_top;
      else if (!r.secondary)
      begin
         e.fwd_down = c[1] && in_mm;
         e.single_xfer = in_mm && (r.command == CMD_MEM_READ);
      end
      else if (r.is_io)
         e.fwd_up = c[2] && (!in_io || isa_top);
      else
         e.fwd_up = c[2] && !in_mm && !c[4] && !c[5];
      return e;
   endfunction : expect_dec

   // ------------------------------------------------------------------
   // drivers
   // ------------------------------------------------------------------
   task automatic cfg_acc(input logic wr, input logic [7:0] a, input logic [3:0] be,
                          input logic [31:0] wd, input logic [31:0] exp);
      @(posedge i_clk);
      cfg <= '{wr: wr, rd: !wr, addr: a, be: be, wdata: wd};
      if (!wr)
         rq.push_back(exp);
      @(posedge i_clk);
      cfg <= '0;
   endtask : cfg_acc

   task automatic setwin(input logic [15:0] bh, input logic [15:0] lh,
                         input logic [3:0] bn, input logic [3:0] ln,
                         input logic [11:0] mb, input logic [11:0] ml);
      ctl <= '0;
      cfg_acc(1, OFF_IO_WINDOW_BASE_LOW, 4'h3, {16'h0, ln, 4'h0, bn, 4'h0}, 0);
      cfg_acc(1, OFF_MMIO_WINDOW_BASE, 4'hF, {ml, 4'hF, mb, 4'hF}, 0);
      cfg_acc(1, OFF_IO_WINDOW_BASE_HIGH, 4'hF, {lh, bh}, 0);
      cfg_acc(0, OFF_IO_WINDOW_BASE_LOW, 4'hF, 0, {16'h0, ln, 4'h1, bn, 4'h1});
      cfg_acc(0, OFF_MMIO_WINDOW_BASE, 4'hF, 0, {ml, 4'h0, mb, 4'h0});
      cfg_acc(0, OFF_IO_WINDOW_BASE_HIGH, 4'hF, 0, {lh, bh});
      iob = {bh, bn, 12'h000};
      iol = {lh, ln, 12'hFFF};
      mmb = {mb, 20'h00000};
      mml = {ml, 20'hFFFFF};
   endtask : setwin

   task automatic run_rand(input int n);
      logic [31:0] pick [8];
      bimad_req_s  r;
      logic [5:0]  c;
      pick = '{iob, iol, iob - 1, iol + 1, mmb, mml, mml + 1, 32'h0001_0000};
      repeat (n)
      begin
         @(posedge i_clk);
         c = 6'($urandom);
         r.valid = 1'b1;
         r.secondary = 1'($urandom);
         r.is_io = 1'($urandom);
         r.command = ($urandom % 2) ? CMD_MEM_READ : 4'($urandom);
         r.addr = pick[$urandom % 8] ^ {22'h0, 2'($urandom), 8'h00};
         issue <= r;
         ctl <= c;
         dq.push_back(expect_dec(r, c));
      end
      @(posedge i_clk);
      issue <= '0;
      ctl <= '0;
      repeat (3) @(posedge i_clk);
   endtask : run_rand

   task automatic end_sim;
      $display("Checks %0d mismatches %0d", tests_run, failures);
      if (failures == 0 && tests_run > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask : end_sim

   // ------------------------------------------------------------------
   // monitor and watchdog
   // ------------------------------------------------------------------
   always @(negedge i_clk)
   begin
      if (dec.valid === 1'b1)
      begin
         e_dec = (dq.size() != 0) ? dq.pop_front() : '0;
         tests_run++;
         if (dec !== e_dec)
         begin
            failures++;
            $display("Error o_dec expected %h seen %h", e_dec, dec);
         end
      end
      if (rvalid === 1'b1)
      begin
         e_rd = (rq.size() != 0) ? rq.pop_front() : 32'hDEAD_BEEF;
         tests_run++;
         if (rdata !== e_rd)
         begin
            failures++;
            $display("Error o_cfg_rdata expected %h seen %h", e_rd, rdata);
         end
      end
   end

   always @(posedge i_clk)
   begin
      cycles++;
      if (cycles == 3000)
      begin
         failures++;
         end_sim;
      end
   end

   // ------------------------------------------------------------------
   // main sequence
   // ------------------------------------------------------------------
   initial
   begin
      i_clk = 1'b0;
      i_reset_n = 1'b0;
      cfg = '0;
      issue = '0;
      ctl = '0;
      failures = 0;
      tests_run = 0;
      cycles = 0;
      void'($urandom(53466));
      iob = 32'h0000_0000;
      iol = 32'h0000_0FFF;
      mmb = 32'h0000_0000;
      mml = 32'h000F_FFFF;
      repeat (8) @(posedge i_clk);
      i_reset_n <= 1'b1;
      cfg_acc(0, OFF_IO_WINDOW_BASE_LOW, 4'hF, 0, 32'h0000_0101);
      cfg_acc(0, OFF_MMIO_WINDOW_BASE, 4'hF, 0, 32'h0000_0000);
      cfg_acc(0, OFF_IO_WINDOW_BASE_HIGH, 4'hF, 0, 32'h0000_0000);
      run_rand(60);
      cfg_acc(1, 8'h40, 4'hF, 32'hFFFF_FFFF, 0);
      cfg_acc(0, 8'h40, 4'hF, 0, 32'h0000_0000);
      cfg_acc(1, OFF_IO_WINDOW_BASE_HIGH, 4'h3, 32'hFFFF_FFFF, 0);
      cfg_acc(0, OFF_IO_WINDOW_BASE_HIGH, 4'hF, 0, 32'h0000_FFFF);
      setwin(16'h0000, 16'h0000, 4'h2, 4'h5, 12'h100, 12'h10F);
      run_rand(150);
      setwin(16'h0001, 16'h0001, 4'h0, 4'hF, 12'h200, 12'h1FF);
      run_rand(150);
      setwin(16'h0000, 16'h0000, 4'h6, 4'h5, 12'hFFF, 12'hFFF);
      run_rand(150);
      // mid-run reset must bring the windows back
      i_reset_n <= 1'b0;
      repeat (2) @(posedge i_clk);
      i_reset_n <= 1'b1;
      iob = 32'h0000_0000;
      iol = 32'h0000_0FFF;
      mmb = 32'h0000_0000;
      mml = 32'h000F_FFFF;
      cfg_acc(0, OFF_IO_WINDOW_BASE_LOW, 4'hF, 0, 32'h0000_0101);
      cfg_acc(0, OFF_MMIO_WINDOW_BASE, 4'hF, 0, 32'h0000_0000);
      cfg_acc(0, OFF_IO_WINDOW_BASE_HIGH, 4'hF, 0, 32'h0000_0000);
      run_rand(40);
      repeat (3) @(posedge i_clk);
      if (dq.size() != 0 || rq.size() != 0)
         failures++;
      end_sim;
   end
endmodule : bimad_decoder_tb_top
